/* File: tcc_commutation.sv */
`timescale 1ns/1ps
module tcc_commutation #(
   parameter int PULSES_PER_REV = 1,
   parameter logic [15:0] CARRIER_DIV = 16'h0001,
   parameter int CNT_W = 20,
   parameter int LA_W = 8,
   parameter int DUTY_W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // digitised hall comparator pins
   input wire logic hall_u_plus,
   input wire logic hall_u_minus,
   input wire logic hall_v_plus,
   input wire logic hall_v_minus,
   input wire logic hall_w_plus,
   input wire logic hall_w_minus,
   // control pins
   input wire logic rotation_direction_in,
   input wire logic direction_test_level_in,
   input wire logic mode_reset_in,
   input wire logic mode_elevated_in,
   input wire logic overcurrent_sense_in,
   // converter codes, same clock
   input wire logic [DUTY_W-1:0] speed_command_in,
   input wire logic [LA_W-1:0] lead_angle_setting,
   // drive outputs
   output logic phase_u_high_drive,
   output logic phase_u_low_drive,
   output logic phase_v_high_drive,
   output logic phase_v_low_drive,
   output logic phase_w_high_drive,
   output logic phase_w_low_drive,
   output logic rotation_pulse_out
);
   import tcc_pkg::*;

   localparam int PW = CNT_W + 8;

   // pin synchronisers
   logic [PIN_N-1:0] pins;
   logic [PIN_N-1:0] s1_q, s2_q, s3_q, pin_q, pin_d;

   assign pins = {overcurrent_sense_in, mode_elevated_in, mode_reset_in,
                  direction_test_level_in, rotation_direction_in,
                  hall_w_minus, hall_w_plus, hall_v_minus, hall_v_plus,
                  hall_u_minus, hall_u_plus};

   always_comb begin
      pin_d = pin_q;
      for (int i = 0; i < PIN_N; i++) begin
         if (s2_q[i] == s3_q[i]) pin_d[i] = s3_q[i];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         pin_q <= '0;
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
         pin_q <= pin_d;
      end
   end

   // commutation state
   logic [2:0] hall_q, hall_d, e_q, e_d;
   logic [15:0] div_q, div_d;
   logic [DUTY_W-1:0] tri_q, tri_d;
   logic up_q, up_d, oc_q, oc_d, adv_q, adv_d, fg_q, fg_d;
   logic [CNT_W-1:0] cnt_q, cnt_d, pcnt_q, pcnt_d, period_q, period_d;
   tcc_drive_s prev_q, prev_d, out_q, out_d;
   tcc_mode_e mode_q, mode_d;
   logic [31:0] ctrl_q, ctrl_d;

   logic tick, cstart, pwm_on, sys_clr, dir, valid, hall_edge, ovl, off;
   logic [2:0] pos, base, e;
   logic [LEAD_W-1:0] lead_code;
   logic [PW-1:0] prod;
   logic [CNT_W-1:0] quot, target;
   tcc_drive_s cur, drv;
   logic [2:0] hi, lo;

   assign sys_clr = pin_q[PIN_TEST];
   assign dir = pin_q[PIN_DIR];
   assign lead_code = lead_angle_setting[LA_W-1 -: LEAD_W];
   assign tick = (div_q == CARRIER_DIV - 16'h0001);
   assign cstart = tick && !up_q && (tri_q == '0);
   assign pwm_on = (speed_command_in > tri_q);

   always_comb begin
      // hall comparators with hold while plus and minus agree
      hall_d = hall_q;
      for (int i = 0; i < 3; i++) begin
         if (pin_q[2*i] != pin_q[2*i+1]) hall_d[i] = pin_q[2*i];
      end
      hall_edge = (hall_d != hall_q);
      pos = tcc_hall_pos(hall_q);
      valid = (pos != POS_BAD);

      // triangular carrier, never stopped by the reset state
      div_d = tick ? '0 : div_q + 16'h0001;
      tri_d = tri_q;
      up_d = up_q;
      if (tick) begin
         if (up_q) begin
            if (tri_q == '1) begin
               up_d = 1'b0;
               tri_d = tri_q - 1'b1;
            end else begin
               tri_d = tri_q + 1'b1;
            end
         end else begin
            if (tri_q == '0) begin
               up_d = 1'b1;
               tri_d = tri_q + 1'b1;
            end else begin
               tri_d = tri_q - 1'b1;
            end
         end
      end
      oc_d = pin_q[PIN_OC] | (oc_q & ~cstart);

      // step period measurement
      period_d = period_q;
      cnt_d = (cnt_q == '1) ? cnt_q : cnt_q + 1'b1;
      prod = PW'(period_q) * PW'(lead_code) * PW'(LEAD_NUM);
      quot = CNT_W'(prod / PW'(LEAD_DEN));
      target = period_q - quot;
      adv_d = adv_q;
      if (hall_edge) begin
         period_d = cnt_q;
         cnt_d = '0;
         adv_d = 1'b0;
      end else if (valid && lead_code != '0 && cnt_q >= target) begin
         adv_d = 1'b1;
      end

      // reverse energises the opposite pair; lead moves one step ahead
      base = dir ? tcc_add6(pos, HALF_TURN) : pos;
      e = adv_q ? tcc_add6(base, dir ? STEP_REV : STEP_FWD) : base;
      if (!valid) e = POS_BAD;
      e_d = e;
      prev_d = prev_q;
      pcnt_d = (pcnt_q == '1) ? pcnt_q : pcnt_q + 1'b1;
      if (e != e_q) begin
         prev_d = tcc_pattern(e_q);
         pcnt_d = '0;
      end

      if (pin_q[PIN_HIGH]) mode_d = TCC_W120;
      else if (pin_q[PIN_MODE]) mode_d = TCC_OFF;
      else mode_d = TCC_W150;

      // 150 mode keeps the outgoing switch on for half a step
      ovl = (mode_q == TCC_W150) && (pcnt_q < (period_q >> 1));
      cur = tcc_pattern(e);
      drv.hi = cur.hi | (ovl ? prev_q.hi : 3'b000);
      drv.lo = cur.lo | (ovl ? prev_q.lo : 3'b000);
      lo = drv.lo & ~drv.hi;
      hi = drv.hi & ~drv.lo & {3{pwm_on & ~oc_d}};
      off = (mode_q == TCC_OFF) || !valid || !ctrl_q[CTRL_EN];
      out_d = off ? '0 : '{hi: hi, lo: lo};
      fg_d = (PULSES_PER_REV == 3) ? ^hall_q : hall_q[0];

      if (sys_clr) begin
         hall_d = '0;
         e_d = '0;
         div_d = '0;
         tri_d = '0;
         up_d = 1'b1;
         oc_d = 1'b0;
         adv_d = 1'b0;
         cnt_d = '0;
         pcnt_d = '0;
         period_d = '0;
         prev_d = '0;
         out_d = '0;
         fg_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hall_q <= '0;
         e_q <= '0;
         div_q <= '0;
         tri_q <= '0;
         up_q <= 1'b1;
         oc_q <= 1'b0;
         adv_q <= 1'b0;
         cnt_q <= '0;
         pcnt_q <= '0;
         period_q <= '0;
         prev_q <= '0;
         out_q <= '0;
         fg_q <= 1'b0;
         mode_q <= TCC_W150;
      end else begin
         hall_q <= hall_d;
         e_q <= e_d;
         div_q <= div_d;
         tri_q <= tri_d;
         up_q <= up_d;
         oc_q <= oc_d;
         adv_q <= adv_d;
         cnt_q <= cnt_d;
         pcnt_q <= pcnt_d;
         period_q <= period_d;
         prev_q <= prev_d;
         out_q <= out_d;
         fg_q <= fg_d;
         mode_q <= mode_d;
      end
   end

   assign phase_u_high_drive = out_q.hi[0];
   assign phase_v_high_drive = out_q.hi[1];
   assign phase_w_high_drive = out_q.hi[2];
   assign phase_u_low_drive = out_q.lo[0];
   assign phase_v_low_drive = out_q.lo[1];
   assign phase_w_low_drive = out_q.lo[2];
   assign rotation_pulse_out = fg_q;

   // bus slave, zero wait states
   logic acc, wr_q, wr_d, rdy_q;
   logic [7:0] ad_q, ad_d;
   logic [31:0] rd_q, rd_d, stat;

   assign acc = hsel && hready && htrans[1];

   always_comb begin
      stat = '0;
      stat[STAT_HALL +: 3] = hall_q;
      stat[STAT_POS +: 3] = pos;
      stat[STAT_DIR] = dir;
      stat[STAT_OC] = oc_q;
      stat[STAT_ADV] = adv_q;
      stat[STAT_MODE +: 3] = mode_q;
      wr_d = acc && hwrite;
      ad_d = acc ? haddr[7:0] : ad_q;
      ctrl_d = ctrl_q;
      if (wr_q && ad_q == ADDR_CTRL) ctrl_d = hwdata;
      rd_d = '0;
      if (acc && !hwrite) begin
         case (haddr[7:0])
            ADDR_CTRL: rd_d = ctrl_d;
            ADDR_STAT: rd_d = stat;
            ADDR_PER: rd_d = 32'(period_q);
            default: rd_d = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_q <= 1'b0;
         ad_q <= '0;
         ctrl_q <= CTRL_RST;
         rd_q <= '0;
         rdy_q <= 1'b1;
      end else begin
         rdy_q <= 1'b1;
         wr_q <= wr_d;
         ad_q <= ad_d;
         ctrl_q <= ctrl_d;
         rd_q <= rd_d;
      end
   end

   assign hrdata = rd_q;
   assign hreadyout = rdy_q;
   assign hresp = 1'b0;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   property p_off_state;
      (mode_q == TCC_OFF) |=> (out_q == '0);
   endproperty
   a_off_state: assert property (p_off_state) else $error("drive on in reset state");

   property p_bad_hall;
      !valid && !sys_clr |=> (out_q == '0);
   endproperty
   a_bad_hall: assert property (p_bad_hall) else $error("drive on with bad hall");

   property p_oc_hi;
      oc_q |-> ##0 (out_q.hi == '0) or ##1 (out_q.hi == '0);
   endproperty
   a_oc_hi: assert property (p_oc_hi) else $error("high side on in overcurrent");

   property p_no_shoot;
      (out_q.hi & out_q.lo) == '0;
   endproperty
   a_no_shoot: assert property (p_no_shoot) else $error("shoot-through");

   property p_chop_hi;
      (out_q.hi != '0) |-> $past(pwm_on);
   endproperty
   a_chop_hi: assert property (p_chop_hi) else $error("high side on outside pwm");

   property p_carrier_runs;
      (mode_q == TCC_OFF) && tick && !sys_clr |=> (tri_q != $past(tri_q));
   endproperty
   a_carrier_runs: assert property (p_carrier_runs) else $error("carrier halted");

   property p_sys_clr;
      sys_clr |=> (period_q == '0) && (out_q == '0) && !adv_q;
   endproperty
   a_sys_clr: assert property (p_sys_clr) else $error("test reset ignored");

   property p_fwd;
      valid && !dir && !adv_q |-> (e == pos);
   endproperty
   a_fwd: assert property (p_fwd) else $error("forward step wrong");

   property p_lead_zero;
      (lead_code == '0) && !adv_q |=> !adv_q;
   endproperty
   a_lead_zero: assert property (p_lead_zero) else $error("advance at zero lead");

   property p_mode120;
      (mode_q == TCC_W120) |-> !ovl;
   endproperty
   a_mode120: assert property (p_mode120) else $error("overlap in 120 mode");

   property p_fg;
      !sys_clr |=> rotation_pulse_out == $past(fg_d);
   endproperty
   a_fg: assert property (p_fg) else $error("pulse output wrong");

   c_hall_step: cover property (valid && hall_edge);
   c_advance: cover property ($rose(adv_q));
   c_oc: cover property ($rose(oc_q) ##[1:600] $fell(oc_q));
   c_rev: cover property (dir && out_q.lo != '0);
endmodule : tcc_commutation

/* File: tcc_pkg.sv */
package tcc_pkg;
   // register byte addresses, low address byte only
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_PER = 8'h08;
   localparam logic [31:0] CTRL_RST = 32'h0000_0001;
   localparam int CTRL_EN = 0;
   // status fields
   localparam int STAT_HALL = 0;
   localparam int STAT_POS = 4;
   localparam int STAT_DIR = 8;
   localparam int STAT_OC = 9;
   localparam int STAT_ADV = 10;
   localparam int STAT_MODE = 12;
   // synchronised pin vector positions
   localparam int PIN_N = 11;
   localparam int PIN_DIR = 6;
   localparam int PIN_TEST = 7;
   localparam int PIN_MODE = 8;
   localparam int PIN_HIGH = 9;
   localparam int PIN_OC = 10;
   // lead: 28 deg over 15 code steps, against a 60 deg step
   localparam int LEAD_W = 4;
   localparam logic [2:0] LEAD_NUM = 3'h7;
   localparam logic [7:0] LEAD_DEN = 8'he1;
   localparam logic [3:0] STEPS = 4'h6;
   localparam logic [2:0] POS_BAD = 3'h7;
   localparam logic [2:0] HALF_TURN = 3'h3;
   localparam logic [2:0] STEP_FWD = 3'h1;
   localparam logic [2:0] STEP_REV = 3'h5;

   typedef enum logic [2:0] {
      TCC_OFF = 3'b001,
      TCC_W150 = 3'b010,
      TCC_W120 = 3'b100
   } tcc_mode_e;

   // bit 0 = U, 1 = V, 2 = W
   typedef struct packed {
      logic [2:0] hi;
      logic [2:0] lo;
   } tcc_drive_s;

   function automatic logic [2:0] tcc_add6(input logic [2:0] a, input logic [2:0] b);
      logic [3:0] t;
      t = {1'b0, a} + {1'b0, b};
      return (t >= STEPS) ? 3'(t - STEPS) : t[2:0];
   endfunction : tcc_add6

   // hall code {w,v,u} to forward position 0..5
   function automatic logic [2:0] tcc_hall_pos(input logic [2:0] h);
      case (h)
         3'b001: return 3'h0;
         3'b011: return 3'h1;
         3'b010: return 3'h2;
         3'b110: return 3'h3;
         3'b100: return 3'h4;
         3'b101: return 3'h5;
         default: return POS_BAD;
      endcase
   endfunction : tcc_hall_pos

   function automatic tcc_drive_s tcc_pattern(input logic [2:0] e);
      case (e)
         3'h0: return '{hi: 3'b001, lo: 3'b010};
         3'h1: return '{hi: 3'b001, lo: 3'b100};
         3'h2: return '{hi: 3'b010, lo: 3'b100};
         3'h3: return '{hi: 3'b010, lo: 3'b001};
         3'h4: return '{hi: 3'b100, lo: 3'b001};
         3'h5: return '{hi: 3'b100, lo: 3'b010};
         default: return '{hi: 3'b000, lo: 3'b000};
      endcase
   endfunction : tcc_pattern
endpackage : tcc_pkg

/* File: tcc_hall_model.sv */
`timescale 1ns/1ps
module tcc_hall_model (
   // clock
   input wire logic clk,
   // hall code {w,v,u} from the bench
   input wire logic [2:0] code,
   // bridge drives, hi over lo
   input wire tcc_pkg::tcc_drive_s drv,
   // comparator pins
   output logic [2:0] plus,
   output logic [2:0] minus,
   // clock cycles seen with both switches of any leg on
   output int shoot
);
   import tcc_pkg::*;
   int shoot_cnt = 0;
   // sensors always drive a complementary pair
   assign plus = code;
   assign minus = ~code;
   assign shoot = shoot_cnt;
   always @(negedge clk) begin
      if ((drv.hi & drv.lo) != 3'h0) shoot_cnt <= shoot_cnt + 1;
   end
endmodule : tcc_hall_model

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import tcc_pkg::*;
   localparam int D = 1000;
   localparam logic [2:0] HALL_T [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
   localparam logic [2:0] HI_T [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
   localparam logic [2:0] LO_T [6] = '{3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2};
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic hsel = 1'b0, hwrite = 1'b0, dir = 1'b0, tst = 1'b0, mrst = 1'b0, melv = 1'b0;
   logic oc = 1'b0, hrdy_n = 1'b0, hrs_n = 1'b0, pulse_n = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrd_n = 32'h0, hrdata;
   logic [1:0] htrans = 2'h0;
   logic [7:0] lead = 8'h00;
   logic [2:0] code = 3'h0;
   logic [2:0] hp, hm;
   logic hreadyout, hresp, pulse;
   wire tcc_drive_s drv;
   int mismatches = 0, comparisons = 0, shoot, rises = 0, pos = 5;
   always #2.5 clk = ~clk;
   always @(negedge clk) begin
      hrdy_n <= hreadyout;
      hrd_n <= hrdata;
      hrs_n <= hresp;
      pulse_n <= pulse;
      if (pulse === 1'b1 && pulse_n === 1'b0) rises <= rises + 1;
   end
   tcc_commutation #(.PULSES_PER_REV(1)) u_tcc_commutation (
      .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .hall_u_plus(hp[0]), .hall_u_minus(hm[0]), .hall_v_plus(hp[1]),
      .hall_v_minus(hm[1]), .hall_w_plus(hp[2]), .hall_w_minus(hm[2]),
      .rotation_direction_in(dir), .direction_test_level_in(tst),
      .mode_reset_in(mrst), .mode_elevated_in(melv), .overcurrent_sense_in(oc),
      .speed_command_in(8'hff), .lead_angle_setting(lead),
      .phase_u_high_drive(drv.hi[0]), .phase_u_low_drive(drv.lo[0]),
      .phase_v_high_drive(drv.hi[1]), .phase_v_low_drive(drv.lo[1]),
      .phase_w_high_drive(drv.hi[2]), .phase_w_low_drive(drv.lo[2]),
      .rotation_pulse_out(pulse));
   tcc_hall_model u_tcc_hall_model (.clk(clk), .code(code), .drv(drv), .plus(hp),
      .minus(hm), .shoot(shoot));
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude
   task automatic cmp_reg(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : cmp_reg
   task automatic cmp_pin(input string n, input logic [2:0] e, input logic [2:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %b seen %b", n, e, g);
      end
   endtask : cmp_pin
   // one single transfer, held until hready is seen high
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      int n;
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      n = 0;
      do begin @(posedge clk); n++; end while (hrdy_n !== 1'b1 && n < 64);
      htrans <= 2'h0;
      hwdata <= wd;
      do begin @(posedge clk); n++; end while (hrdy_n !== 1'b1 && n < 64);
      rd = hrd_n;
      hsel <= 1'b0;
      if (n >= 64) begin
         mismatches++;
         conclude();
      end
      cmp_reg("hresp", 32'h0, {31'h0, hrs_n});
   endtask : bus
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask : wr
   task automatic chk_rd(input string n, input logic [31:0] a, input logic [31:0] m,
                         input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      cmp_reg(n, e, x & m);
   endtask : chk_rd
   task automatic set_hall(input int p);
      @(posedge clk);
      code <= HALL_T[p];
   endtask : set_hall
   // or of high sides, and/or of low sides over a window
   task automatic win(input int s, input int n, input logic [2:0] he, input logic [2:0] le);
      logic [2:0] ho, la, lr;
      ho = 3'h0;
      la = 3'h7;
      lr = 3'h0;
      repeat (s) @(negedge clk);
      repeat (n) begin
         @(negedge clk);
         ho = ho | drv.hi;
         la = la & drv.lo;
         lr = lr | drv.lo;
      end
      cmp_pin("high_or", he, ho);
      cmp_pin("low_and", le, la);
      cmp_pin("low_or", le, lr);
   endtask : win
   task automatic run_step(input int p, input int e, input int pe, input bit ovl);
      set_hall(p);
      win(30, 420, HI_T[e] | (ovl ? HI_T[pe] : 3'h0), LO_T[e] | (ovl ? LO_T[pe] : 3'h0));
      win(110, 390, HI_T[e], LO_T[e]);
      repeat (50) @(posedge clk);
   endtask : run_step
   task automatic t_ctrl();
      chk_rd("ctrl", {24'h0, ADDR_CTRL}, 32'hffff_ffff, 32'h1);
      win(4, 100, 3'h0, 3'h0);
      @(posedge clk);
      code <= 3'h7;
      win(10, 100, 3'h0, 3'h0);
      wr({24'h0, ADDR_CTRL}, 32'h0);
      chk_rd("ctrl", {24'h0, ADDR_CTRL}, 32'hffff_ffff, 32'h0);
      wr(32'h0c, 32'hffff_ffff);
      chk_rd("unmapped", 32'h0c, 32'hffff_ffff, 32'h0);
      wr({24'h0, ADDR_CTRL}, 32'h1);
      chk_rd("mode", {24'h0, ADDR_STAT}, 32'h7000, 32'h2000);
   endtask : t_ctrl
   task automatic t_fwd();
      int r0;
      melv <= 1'b1;
      r0 = 0;
      for (int k = 0; k < 12; k++) begin
         if (k == 6) r0 = rises;
         pos = (pos + 1) % 6;
         run_step(pos, pos, 0, 0);
      end
      cmp_reg("pulses", 32'h1, rises - r0);
      chk_rd("mode", {24'h0, ADDR_STAT}, 32'h7000, 32'h4000);
   endtask : t_fwd
   task automatic t_rev();
      dir <= 1'b1;
      for (int k = 0; k < 6; k++) begin
         pos = (pos + 5) % 6;
         run_step(pos, (pos + 3) % 6, 0, 0);
      end
      dir <= 1'b0;
   endtask : t_rev
   task automatic t_lead(input logic [3:0] c);
      int ta;
      lead <= {c, 4'h0};
      ta = D - (D * c * 7) / 225;
      repeat (2) begin
         pos = (pos + 1) % 6;
         set_hall(pos);
         repeat (D) @(posedge clk);
      end
      pos = (pos + 1) % 6;
      set_hall(pos);
      win(30, ta - 80, HI_T[pos], LO_T[pos]);
      win(100, D - 60 - ta, HI_T[(pos + 1) % 6], LO_T[(pos + 1) % 6]);
      @(posedge clk);
      lead <= 8'h00;
      repeat (10) @(posedge clk);
   endtask : t_lead
   task automatic t_150();
      melv <= 1'b0;
      pos = (pos + 1) % 6;
      set_hall(pos);
      repeat (D) @(posedge clk);
      for (int k = 0; k < 6; k++) begin
         pos = (pos + 1) % 6;
         run_step(pos, pos, (pos + 5) % 6, 1);
      end
   endtask : t_150
   task automatic t_oc();
      melv <= 1'b1;
      pos = (pos + 1) % 6;
      set_hall(pos);
      repeat (30) @(posedge clk);
      oc <= 1'b1;
      win(10, 300, 3'h0, LO_T[pos]);
      @(posedge clk);
      oc <= 1'b0;
      win(0, 600, HI_T[pos], LO_T[pos]);
      repeat (50) @(posedge clk);
   endtask : t_oc
   task automatic t_rststate();
      logic [31:0] x;
      melv <= 1'b0;
      mrst <= 1'b1;
      repeat (3) begin
         pos = (pos + 1) % 6;
         set_hall(pos);
         win(30, 900, 3'h0, 3'h0);
         repeat (70) @(posedge clk);
      end
      chk_rd("mode", {24'h0, ADDR_STAT}, 32'h7000, 32'h1000);
      bus(1'b0, {24'h0, ADDR_PER}, 32'h0, x);
      cmp_reg("period_near", 32'h1, {31'h0, x > 32'd990 && x < 32'd1012});
      mrst <= 1'b0;
   endtask : t_rststate
   task automatic t_test();
      melv <= 1'b1;
      tst <= 1'b1;
      win(10, 300, 3'h0, 3'h0);
      @(posedge clk);
      tst <= 1'b0;
      repeat (2) begin
         pos = (pos + 1) % 6;
         set_hall(pos);
         repeat (D) @(posedge clk);
      end
      pos = (pos + 1) % 6;
      run_step(pos, pos, 0, 0);
      chk_rd("ctrl", {24'h0, ADDR_CTRL}, 32'hffff_ffff, 32'h1);
   endtask : t_test
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      t_ctrl();
      t_fwd();
      t_rev();
      t_lead(4'hf);
      t_lead(4'h8);
      t_150();
      t_oc();
      t_rststate();
      t_test();
      cmp_reg("shoot_through", 32'h0, shoot);
      conclude();
   end
endmodule : tb_top
